// >>> hdl/twm_master_tx.sv
`timescale 1ns/1ns
// How it works
// - master work always begins by driving a start condition
// - address direction bit chooses master transmit or master receive mode
// - start waits until the bus is seen free
// - after start, flag sets and status shows 08
// - writing one to the flag clears it and releases the next step
// - bus stays suspended while the flag is set
// - after address-write and ack sample, flag sets, status 18 or 20
// - data write with flag low is dropped and sets write collision
// - bytes repeat load-then-clear until stop or repeated start
// - after repeated start, status 10 and the bus stays owned
// - address-read after repeated start switches to master receive
// - stop request bit clears itself once stop is on the bus
// - start and stop together give stop then start, stop bit cleared
`include "twm_consts.svh"
module twm_master_tx #(
    parameter int QTR_CYC = `TWM_QTR_CYC
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // two-wire pins, open drain: oe high pulls the line low
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // status towards the core
    output logic irq,
    output logic master_rx_mode
);
    import twm_pkg::*;

    initial begin
        if (QTR_CYC < 2 || QTR_CYC > 255) begin
            $error("twm_master_tx: QTR_CYC out of range");
        end
    end

    localparam logic [7:0] QTR_LAST = 8'(QTR_CYC - 1);

    twm_regs_type r_r;
    twm_regs_type r_nxt;

    // a pin is taken once second and third stage agree
    function automatic logic settle(input logic [2:0] s, input logic prev);
        settle = (s[1] == s[2]) ? s[2] : prev;
    endfunction

    logic acc;
    logic wr;
    logic rd;
    logic scl_v;
    logic sda_v;
    logic qtr_end;

    assign acc = psel && penable;
    assign wr = acc && pwrite;
    assign rd = acc && !pwrite;
    assign pready = 1'b1;
    assign pslverr = acc && (paddr != `TWM_ADDR_CTRL) && (paddr != `TWM_ADDR_STATUS)
                     && (paddr != `TWM_ADDR_DATA);
    assign prdata = r_r.prdata;
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe = r_r.scl_oe;
    assign sda_oe = r_r.sda_oe;
    assign irq = r_r.ctrl[`TWM_BIT_FLAG] && r_r.ctrl[`TWM_BIT_IRQ_EN];
    assign master_rx_mode = (r_r.st == TWM_MRX);
    assign scl_v = settle(r_r.scl_s, r_r.scl_q);
    assign sda_v = settle(r_r.sda_s, r_r.sda_q);
    assign qtr_end = (r_r.tick == QTR_LAST);

    // next-state logic for the whole block
    always_comb begin
        logic set_flag;
        logic flag_clr;
        logic [7:0] w;
        set_flag = 1'b0;
        flag_clr = 1'b0;
        w = pwdata[7:0];
        r_nxt = r_r;
        r_nxt.scl_s = {r_r.scl_s[1:0], scl_in};
        r_nxt.sda_s = {r_r.sda_s[1:0], sda_in};
        r_nxt.scl_q = scl_v;
        r_nxt.sda_q = sda_v;
        r_nxt.tick = qtr_end ? 8'h00 : r_r.tick + 8'h01;
        if (qtr_end) begin
            r_nxt.phase = r_r.phase + 2'd1;
        end

        // bus busy: set by a start seen on the wire, cleared by a stop
        if (r_r.scl_q && scl_v && r_r.sda_q && !sda_v) begin
            r_nxt.busy = 1'b1;
        end else if (r_r.scl_q && scl_v && !r_r.sda_q && sda_v) begin
            r_nxt.busy = 1'b0;
        end

        // register writes
        if (wr && paddr == `TWM_ADDR_CTRL) begin
            flag_clr = w[`TWM_BIT_FLAG];
            r_nxt.ctrl[`TWM_BIT_ACK] = w[`TWM_BIT_ACK];
            r_nxt.ctrl[`TWM_BIT_START] = w[`TWM_BIT_START];
            r_nxt.ctrl[`TWM_BIT_STOP] = w[`TWM_BIT_STOP];
            r_nxt.ctrl[`TWM_BIT_EN] = w[`TWM_BIT_EN];
            r_nxt.ctrl[`TWM_BIT_IRQ_EN] = w[`TWM_BIT_IRQ_EN];
            if (flag_clr) begin
                r_nxt.ctrl[`TWM_BIT_FLAG] = 1'b0;
                r_nxt.ctrl[`TWM_BIT_WCOL] = 1'b0;
            end
        end
        if (wr && paddr == `TWM_ADDR_DATA) begin
            if (r_r.ctrl[`TWM_BIT_FLAG]) begin
                r_nxt.data = w;
            end else begin
                r_nxt.ctrl[`TWM_BIT_WCOL] = 1'b1;
            end
        end

        // sequencer; bus steps wait for quarter-bit boundaries, idle, hold and receive act on the write at once
        case (r_r.st)
            TWM_IDLE: begin
                if (flag_clr && w[`TWM_BIT_EN] && w[`TWM_BIT_START]) begin
                    r_nxt.st = TWM_WAIT_FREE;
                    r_nxt.restart_after = 1'b0;
                end
            end
            TWM_WAIT_FREE: begin
                if (!r_r.busy && scl_v && sda_v && qtr_end) begin
                    r_nxt.st = TWM_START;
                    r_nxt.phase = 2'd0;
                end
            end
            TWM_START: begin
                // release sda with scl high, then pull sda, then scl
                if (qtr_end) begin
                    case (r_r.phase)
                        2'd0: begin
                            r_nxt.sda_oe = 1'b0;
                            r_nxt.scl_oe = 1'b0;
                        end
                        2'd1: r_nxt.sda_oe = 1'b1;
                        2'd2: r_nxt.scl_oe = 1'b1;
                        default: begin
                            set_flag = 1'b1;
                            r_nxt.status = r_r.restart_after ? `TWM_ST_RESTART : `TWM_ST_START;
                            r_nxt.ctrl[`TWM_BIT_START] = 1'b0;
                            r_nxt.addr_step = 1'b1;
                            r_nxt.busy = 1'b1;
                            r_nxt.st = TWM_HOLD;
                        end
                    endcase
                end
            end
            TWM_HOLD: begin
                // scl held low while the flag stands
                if (flag_clr && w[`TWM_BIT_EN]) begin
                    r_nxt.phase = 2'd0;
                    r_nxt.tick = 8'h00;
                    if (w[`TWM_BIT_STOP]) begin
                        r_nxt.restart_after = w[`TWM_BIT_START];
                        r_nxt.st = TWM_STOP;
                    end else if (w[`TWM_BIT_START]) begin
                        r_nxt.restart_after = 1'b1;
                        r_nxt.sda_oe = 1'b0;
                        r_nxt.st = TWM_START;
                    end else if (r_r.status != `TWM_ST_AR_ACK) begin
                        r_nxt.shift = r_r.data;
                        r_nxt.is_read = r_r.addr_step && r_r.data[0];
                        r_nxt.bitn = 4'd0;
                        r_nxt.st = TWM_BITS;
                    end
                end else if (wr && paddr == `TWM_ADDR_CTRL && !w[`TWM_BIT_EN]) begin
                    r_nxt.st = TWM_IDLE;
                end
            end
            TWM_BITS: begin
                // data changes with scl low, stable while scl high
                if (qtr_end) begin
                    case (r_r.phase)
                        2'd0: r_nxt.sda_oe = !r_r.shift[7];
                        2'd1: r_nxt.scl_oe = 1'b0;
                        2'd2: r_nxt.scl_oe = scl_v ? 1'b0 : 1'b0;
                        default: begin
                            r_nxt.scl_oe = 1'b1;
                            r_nxt.shift = {r_r.shift[6:0], 1'b0};
                            r_nxt.bitn = r_r.bitn + 4'd1;
                            if (r_r.bitn == 4'd7) begin
                                r_nxt.st = TWM_ACK;
                            end
                        end
                    endcase
                end
            end
            TWM_ACK: begin
                // release sda, sample the acknowledge with scl high
                if (qtr_end) begin
                    case (r_r.phase)
                        2'd0: r_nxt.sda_oe = 1'b0;
                        2'd1: r_nxt.scl_oe = 1'b0;
                        2'd2: r_nxt.shift[0] = sda_v;
                        default: begin
                            r_nxt.scl_oe = 1'b1;
                            set_flag = 1'b1;
                            if (r_r.addr_step) begin
                                if (r_r.is_read) begin
                                    r_nxt.status = r_r.shift[0] ? `TWM_ST_AR_NACK
                                                                : `TWM_ST_AR_ACK;
                                end else begin
                                    r_nxt.status = r_r.shift[0] ? `TWM_ST_AW_NACK
                                                                : `TWM_ST_AW_ACK;
                                end
                            end else begin
                                r_nxt.status = r_r.shift[0] ? `TWM_ST_DATA_NACK
                                                            : `TWM_ST_DATA_ACK;
                            end
                            r_nxt.addr_step = 1'b0;
                            r_nxt.st = (r_r.is_read && !r_r.shift[0]) ? TWM_MRX : TWM_HOLD;
                        end
                    endcase
                end
            end
            TWM_MRX: begin
                // receive side lives elsewhere; only stop, restart or disabling the unit leave it,
                // and the requested condition then goes out on quarter-bit boundaries
                if (flag_clr && w[`TWM_BIT_EN] && (w[`TWM_BIT_STOP] || w[`TWM_BIT_START])) begin
                    r_nxt.phase = 2'd0;
                    r_nxt.tick = 8'h00;
                    r_nxt.restart_after = w[`TWM_BIT_START];
                    if (w[`TWM_BIT_STOP]) begin
                        r_nxt.st = TWM_STOP;
                    end else begin
                        r_nxt.sda_oe = 1'b0;
                        r_nxt.st = TWM_START;
                    end
                end
            end
            TWM_STOP: begin
                // sda low, scl up, then sda up with scl high
                if (qtr_end) begin
                    case (r_r.phase)
                        2'd0: r_nxt.sda_oe = 1'b1;
                        2'd1: r_nxt.scl_oe = 1'b0;
                        2'd2: r_nxt.sda_oe = 1'b0;
                        default: begin
                            r_nxt.ctrl[`TWM_BIT_STOP] = 1'b0;
                            r_nxt.busy = 1'b0;
                            r_nxt.status = `TWM_ST_IDLE;
                            r_nxt.st = r_r.restart_after ? TWM_WAIT_FREE : TWM_IDLE;
                            r_nxt.restart_after = 1'b0;
                        end
                    endcase
                end
            end
            default: r_nxt.st = TWM_IDLE;
        endcase

        // hardware set wins over a software clear in the same cycle
        if (set_flag) begin
            r_nxt.ctrl[`TWM_BIT_FLAG] = 1'b1;
        end

        // disabling the unit lets go of both lines
        if (!r_nxt.ctrl[`TWM_BIT_EN]) begin
            r_nxt.st = TWM_IDLE;
            r_nxt.scl_oe = 1'b0;
            r_nxt.sda_oe = 1'b0;
        end

        // read data registered for the access phase
        r_nxt.prdata = 32'h0000_0000;
        if (psel && !penable && !pwrite) begin
            case (paddr)
                `TWM_ADDR_CTRL: r_nxt.prdata = {24'h000000, r_nxt.ctrl};
                `TWM_ADDR_STATUS: r_nxt.prdata = {24'h000000, r_nxt.status};
                `TWM_ADDR_DATA: r_nxt.prdata = {24'h000000, r_nxt.data};
                default: r_nxt.prdata = 32'h0000_0000;
            endcase
        end else if (rd) begin
            r_nxt.prdata = r_r.prdata;
        end
    end

    // one register for all state
    always_ff @(posedge clock) begin
        if (rst) begin
            r_r <= '{st: TWM_IDLE, status: `TWM_ST_IDLE, scl_s: 3'h7, sda_s: 3'h7,
                     scl_q: 1'b1, sda_q: 1'b1, default: '0};
        end else begin
            r_r <= r_nxt;
        end
    end
endmodule // twm_master_tx

// >>> pkg/twm_consts.svh
`ifndef TWM_CONSTS_SVH
`define TWM_CONSTS_SVH
// register byte addresses on the apb bus
`define TWM_ADDR_CTRL 8'h00
`define TWM_ADDR_STATUS 8'h04
`define TWM_ADDR_DATA 8'h08
// control register bit positions
`define TWM_BIT_FLAG 7
`define TWM_BIT_ACK 6
`define TWM_BIT_START 5
`define TWM_BIT_STOP 4
`define TWM_BIT_WCOL 3
`define TWM_BIT_EN 2
`define TWM_BIT_IRQ_EN 0
// status codes, prescaler bits masked to zero
`define TWM_ST_START 8'h08
`define TWM_ST_RESTART 8'h10
`define TWM_ST_AW_ACK 8'h18
`define TWM_ST_AW_NACK 8'h20
`define TWM_ST_ARB_LOST 8'h38
`define TWM_ST_DATA_ACK 8'h28
`define TWM_ST_DATA_NACK 8'h30
`define TWM_ST_AR_ACK 8'h40
`define TWM_ST_AR_NACK 8'h48
`define TWM_ST_IDLE 8'hF8
// timing: quarter of a serial bit period
`define TWM_QTR_NS 2500
`define TWM_CLK_NS 50
`define TWM_QTR_CYC (`TWM_QTR_NS / `TWM_CLK_NS)
`endif

// >>> pkg/twm_pkg.sv
package twm_pkg;
    typedef enum logic [3:0] {
        TWM_IDLE, TWM_WAIT_FREE, TWM_START, TWM_BITS, TWM_ACK,
        TWM_HOLD, TWM_STOP, TWM_MRX
    } twm_state_type;

    typedef struct packed {
        twm_state_type st;
        logic [7:0] ctrl;
        logic [7:0] status;
        logic [7:0] data;
        logic [7:0] shift;
        logic [3:0] bitn;
        logic [1:0] phase;
        logic [7:0] tick;
        logic addr_step;
        logic is_read;
        logic restart_after;
        logic busy;
        logic sda_oe;
        logic scl_oe;
        logic [2:0] scl_s;
        logic [2:0] sda_s;
        logic scl_q;
        logic sda_q;
        logic [31:0] prdata;
    } twm_regs_type;
endpackage

// >>> tb/twm_master_tx_asserts.sv
`timescale 1ns/1ns
`include "twm_consts.svh"
module twm_master_tx_asserts (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // two-wire pins and status
    input wire logic scl_in,
    input wire logic scl_out,
    input wire logic scl_oe,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic irq
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // access phase, and one that hits no register
    sequence s_acc;
        psel && penable;
    endsequence
    sequence s_bad;
        s_acc ##0 (paddr != `TWM_ADDR_CTRL && paddr != `TWM_ADDR_STATUS
            && paddr != `TWM_ADDR_DATA);
    endsequence
    a_zero_wait: assert property (s_acc |-> pready) else $error("apb wait state");
    a_unmapped_err: assert property (s_bad |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_mapped_ok: assert property (s_acc ##0 (paddr == `TWM_ADDR_CTRL
        || paddr == `TWM_ADDR_STATUS || paddr == `TWM_ADDR_DATA) |-> !pslverr)
        else $error("mapped access refused");
    a_pins_drain: assert property (!scl_out && !sda_out) else $error("pin driven high");
    // a start is only pulled while the clock line is high and data was free
    a_start_free: assert property ($rose(sda_oe) && !scl_oe |-> scl_in && $past(sda_in))
        else $error("start on busy bus");
    a_flag_holds: assert property (irq |-> scl_oe) else $error("clock released with flag");
    a_flag_stays: assert property (irq && !(psel && penable && pwrite
        && paddr == `TWM_ADDR_CTRL) |=> irq) else $error("flag lost");
    a_reset_quiet: assert property ($fell(rst) |-> !scl_oe && !sda_oe && !irq)
        else $error("lines not idle after reset");
endmodule // twm_master_tx_asserts
bind twm_master_tx twm_master_tx_asserts chk (.clock(clock), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));

// >>> tb/twm_slave_model.sv
`timescale 1ns/1ns
module twm_slave_model (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // resolved bus lines, pulled up
    input wire logic scl,
    input wire logic sda,
    // behaviour and observation
    input wire logic ack_en,
    output logic sda_oe,
    output logic [7:0] last_byte
);
    logic scl_d, sda_d;
    logic [3:0] cnt;
    logic [7:0] sh;
    // receiver: start restarts the bit count, msb first, ack on the ninth clock
    always_ff @(posedge clock) begin
        scl_d <= scl;
        sda_d <= sda;
        if (rst) begin
            cnt <= 4'hF;
            sda_oe <= 1'b0;
        end else if (scl && scl_d && sda_d && !sda) begin
            cnt <= 4'h0;
            sda_oe <= 1'b0;
        end else if (scl && !scl_d && cnt < 4'h9) begin
            cnt <= cnt + 4'h1;
            if (cnt < 4'h8) sh <= {sh[6:0], sda};
        end else if (!scl && scl_d) begin
            // released after the ninth clock so the master can drive again
            sda_oe <= (cnt == 4'h8) && ack_en;
            if (cnt == 4'h8) last_byte <= sh;
            if (cnt == 4'h9) cnt <= 4'h0;
        end
    end
endmodule // twm_slave_model

// >>> tb/two_wire_master_transmit_bench.sv
`timescale 1ns/1ns
`include "twm_consts.svh"
module two_wire_master_transmit_bench;
    logic clock, rst, psel, penable, pwrite, ack_en, e;
    logic pready, pslverr, scl_out, scl_oe, sda_out, sda_oe, irq, master_rx_mode, slv_oe;
    logic [7:0] paddr, got_byte;
    logic [31:0] pwdata, prdata, q;
    int miscompares, samples_checked, n;
    logic [7:0] row_addr [3] = '{8'h00, 8'h04, 8'h0C};
    logic [31:0] row_data [3] = '{32'h00, 32'hF8, 32'h00};
    logic row_err [3] = '{1'b0, 1'b0, 1'b1};
    // open-drain lines with pull-ups
    wire logic scl_w = !scl_oe;
    wire logic sda_w = !(sda_oe || slv_oe);
    twm_master_tx #(.QTR_CYC(4)) uut (.clock(clock), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .scl_in(scl_w), .scl_out(scl_out),
        .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq),
        .master_rx_mode(master_rx_mode));
    twm_slave_model slv (.clock(clock), .rst(rst), .scl(scl_w), .sda(sda_w),
        .ack_en(ack_en), .sda_oe(slv_oe), .last_byte(got_byte));
    // clock
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer; the master waits for pready, never a fixed count
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // optional data load, control write, then wait for the flag and read status
    task step(input logic ld, input logic [7:0] d, input logic [7:0] c, input logic [7:0] st);
        if (ld) apb(1'b1, `TWM_ADDR_DATA, {24'h0, d});
        apb(1'b1, `TWM_ADDR_CTRL, {24'h0, c});
        // let the flag clear land before looking for the next set
        @(posedge clock);
        for (n = 0; n < 4000 && irq !== 1'b1; n++) @(posedge clock);
        repeat (20) @(posedge clock);
        check(scl_oe, 1'b1);
        apb(1'b0, `TWM_ADDR_STATUS, 32'h0);
        check(q, {24'h0, st});
        $display("test step to status %h done", st);
    endtask
    task complete_run;
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // watchdog: the whole sequence needs well under 20000 cycles
    initial begin
        repeat (40000) @(posedge clock);
        miscompares++;
        complete_run;
    end
    initial begin
        miscompares = 0;
        samples_checked = 0;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        ack_en = 1'b1;
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            apb(1'b0, row_addr[i], 32'h0);
            check(q, row_data[i]);
            check(e, row_err[i]);
        end
        $display("test register reset done");
        apb(1'b1, `TWM_ADDR_DATA, 32'h55);
        apb(1'b0, `TWM_ADDR_CTRL, 32'h0);
        check(q, 32'h08);
        step(1'b0, 8'h00, 8'hA5, 8'h08);
        step(1'b1, 8'hA0, 8'h85, 8'h18);
        check(got_byte, 8'hA0);
        step(1'b1, 8'h3C, 8'h85, 8'h28);
        check(got_byte, 8'h3C);
        check(master_rx_mode, 1'b0);
        ack_en <= 1'b0;
        step(1'b1, 8'hC3, 8'h85, 8'h30);
        ack_en <= 1'b1;
        step(1'b0, 8'h00, 8'hA5, 8'h10);
        step(1'b1, 8'hA1, 8'h85, 8'h40);
        check(master_rx_mode, 1'b1);
        step(1'b0, 8'h00, 8'hB5, 8'h08);
        apb(1'b0, `TWM_ADDR_CTRL, 32'h0);
        check(q & 32'h10, 32'h0);
        ack_en <= 1'b0;
        step(1'b1, 8'hA2, 8'h85, 8'h20);
        ack_en <= 1'b1;
        apb(1'b1, `TWM_ADDR_CTRL, 32'h95);
        // poll the control register until the stop bit has cleared itself
        apb(1'b0, `TWM_ADDR_CTRL, 32'h0);
        for (n = 0; n < 400 && q[4] !== 1'b0; n++) apb(1'b0, `TWM_ADDR_CTRL, 32'h0);
        check(q & 32'h90, 32'h0);
        apb(1'b0, `TWM_ADDR_STATUS, 32'h0);
        check(q, 32'hF8);
        check(scl_oe, 1'b0);
        $display("test stop done");
        complete_run;
    end
endmodule // two_wire_master_transmit_bench
